// ### hdl/output_in_regulation_mask_pkg.sv
/*
 * Constants for the power-good drop interrupt mask group.
 * Assumes an 8-bit register port and one lane per regulator.
 */
package output_in_regulation_mask_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] MASK_GROUP_THREE_OFFSET = 8'h3e;
	localparam logic [7:0] MASK_GROUP_THREE_RESET  = 8'hff;
	localparam logic [7:0] READ_UNMAPPED_VALUE     = 8'h00;

	// ==========================================================
	// Field positions inside the mask register
	localparam int BUCK1_DROP_IRQ_MASK_POS   = 0;
	localparam int BUCK2_DROP_IRQ_MASK_POS   = 1;
	localparam int BUCK3_DROP_IRQ_MASK_POS   = 2;
	localparam int BUCK4_DROP_IRQ_MASK_POS   = 3;
	localparam int LINREG1_DROP_IRQ_MASK_POS = 4;
	localparam int LINREG2_DROP_IRQ_MASK_POS = 5;
	localparam int LINREG3_DROP_IRQ_MASK_POS = 6;
	localparam int LINREG4_DROP_IRQ_MASK_POS = 7;

	// ==========================================================
	// Sizes and reset values
	localparam int         LANE_COUNT        = 8;
	localparam logic [7:0] PREV_GOOD_RESET   = 8'h00;	// Unseen = not good
	localparam logic [7:0] LANE_CLEAR        = 8'h00;
	localparam logic [1:0] RST_SYNC_RESET    = 2'h0;
endpackage

// ### hdl/output_in_regulation_drop_if.sv
/*
 * Interface between the mask block and its drop detector.
 * Assumes both ends share one clock; lane order follows the mask bits.
 */
`timescale 1ns/1ps
`default_nettype none
interface output_in_regulation_drop_if;
	logic [7:0] output_in_regulation;	// Power-good per lane
	logic [7:0] reg_enable;			// Regulator enable per lane
	logic [7:0] drop_event;			// Qualified falling-edge pulse

	modport detector (
		input  output_in_regulation,
		input  reg_enable,
		output drop_event
	);
	modport owner (
		output output_in_regulation,
		output reg_enable,
		input  drop_event
	);
endinterface
`default_nettype wire

// ### hdl/output_in_regulation_drop_detect.sv
/*
 * Falling-edge detector for the eight power-good lanes.
 * Assumes inputs are synchronous to the clock and reset is already synced.
 */
`timescale 1ns/1ps
`default_nettype none
module output_in_regulation_drop_detect
	import output_in_regulation_mask_pkg::*;
(
	input  wire logic      i_sys_clk,	// System clock
	input  wire logic      i_rst_sync_b,	// Synced reset, active low
	output_in_regulation_drop_if.detector lanes		// Lane inputs and events
);
	logic [7:0] prev_good;

	// ==========================================================
	// Previous level; starts as not good, so a lane already low when
	// reset lifts is never taken for a drop
	always_ff @(posedge i_sys_clk or negedge i_rst_sync_b) begin
		if (!i_rst_sync_b) begin
			prev_good <= PREV_GOOD_RESET;
		end else begin
			prev_good <= lanes.output_in_regulation;
		end
	end

	// Good-to-bad only, gated by enable so a shutdown is silent
	always_ff @(posedge i_sys_clk or negedge i_rst_sync_b) begin
		if (!i_rst_sync_b) begin
			lanes.drop_event <= LANE_CLEAR;
		end else begin
			lanes.drop_event <= prev_good & ~lanes.output_in_regulation
				& lanes.reg_enable;
		end
	end
endmodule // output_in_regulation_drop_detect
`default_nettype wire

// ### hdl/regulator_power_good_irq_mask.sv
/*
 * Power-good drop interrupt mask for four bucks and four linear regulators.
 * Assumes the serial control port decodes to a byte address, write and
 * read strobes; the status register lives elsewhere and is fed by
 * o_drop_event.
 */
`timescale 1ns/1ps
`default_nettype none
module regulator_power_good_irq_mask
	import output_in_regulation_mask_pkg::*;
(
	input  wire logic       i_sys_clk,		// 100 MHz clock
	input  wire logic       i_rst_b,		// Power-on reset, low
	input  wire logic [7:0] i_reg_addr,		// Register address
	input  wire logic       i_reg_wr,		// Write strobe
	input  wire logic       i_reg_rd,		// Read strobe
	input  wire logic [7:0] i_reg_wdata,		// Write data
	input  wire logic [7:0] i_output_in_regulation,	// Power-good levels
	input  wire logic [7:0] i_reg_enable,		// Regulator enables
	output var  logic [7:0] o_reg_rdata,		// Read data
	output var  logic [7:0] o_mask,			// Mask register copy
	output var  logic [7:0] o_drop_event,		// All drop events, mask ignored
	output var  logic       o_drop_irq		// Forwarded interrupt
);
	logic [1:0] rst_sync;
	logic       rst_sync_b;
	logic [7:0] power_good_irq_mask_group_three;
	logic       hit;
	output_in_regulation_drop_if lanes ();

	// ==========================================================
	// Reset release: asserts at once, releases after two edges
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync <= RST_SYNC_RESET;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_sync[1];

	// ==========================================================
	// Drop detection
	assign lanes.output_in_regulation = i_output_in_regulation;
	assign lanes.reg_enable           = i_reg_enable;

	output_in_regulation_drop_detect u_detect (
		.i_sys_clk    (i_sys_clk),
		.i_rst_sync_b (rst_sync_b),
		.lanes        (lanes)
	);

	// ==========================================================
	// Register port
	assign hit = (i_reg_addr == MASK_GROUP_THREE_OFFSET);

	// Mask register; all lanes masked out of reset
	always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			power_good_irq_mask_group_three <= MASK_GROUP_THREE_RESET;
		end else if (i_reg_wr && hit) begin
			power_good_irq_mask_group_three <= i_reg_wdata;
		end
	end

	// Read data holds until the next read; unmapped reads return zero
	always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			o_reg_rdata <= READ_UNMAPPED_VALUE;
		end else if (i_reg_rd && hit) begin
			o_reg_rdata <= power_good_irq_mask_group_three;
		end else if (i_reg_rd) begin
			o_reg_rdata <= READ_UNMAPPED_VALUE;
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			o_mask <= MASK_GROUP_THREE_RESET;
		end else begin
			o_mask <= power_good_irq_mask_group_three;
		end
	end

	// ==========================================================
	// Event outputs; the status register latches o_drop_event and is
	// cleared by a write of 1, so events flow regardless of mask
	always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			o_drop_event <= LANE_CLEAR;
		end else begin
			o_drop_event <= lanes.drop_event;
		end
	end

	// Only unmasked lanes reach the interrupt line
	always_ff @(posedge i_sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			o_drop_irq <= 1'b0;
		end else begin
			o_drop_irq <= |(lanes.drop_event
				& ~power_good_irq_mask_group_three);
		end
	end

	// ==========================================================
	// Checks
	sequence s_mask_write;
		i_reg_wr && hit;
	endsequence

	sequence s_open_event;
		(lanes.drop_event & ~power_good_irq_mask_group_three) != LANE_CLEAR;
	endsequence

	property p_forward;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		s_open_event |=> o_drop_irq;
	endproperty
	a_forward: assert property (p_forward)
		else $error("unmasked drop event not forwarded");

	property p_block;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		(lanes.drop_event & ~power_good_irq_mask_group_three) == LANE_CLEAR
			|=> !o_drop_irq;
	endproperty
	a_block: assert property (p_block)
		else $error("masked drop event reached interrupt");

	property p_reset_mask;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		$rose(rst_sync_b) |-> power_good_irq_mask_group_three
			== MASK_GROUP_THREE_RESET ##1 o_mask == MASK_GROUP_THREE_RESET;
	endproperty
	a_reset_mask: assert property (p_reset_mask)
		else $error("mask not all ones after reset");

	property p_edge;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		lanes.drop_event != LANE_CLEAR |-> (lanes.drop_event
			& ~($past(i_output_in_regulation, 2)
			& ~$past(i_output_in_regulation, 1))) == LANE_CLEAR;
	endproperty
	a_edge: assert property (p_edge)
		else $error("drop event without a falling edge");

	property p_enable;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		lanes.drop_event != LANE_CLEAR |-> (lanes.drop_event
			& ~$past(i_reg_enable)) == LANE_CLEAR;
	endproperty
	a_enable: assert property (p_enable)
		else $error("drop event on a disabled regulator");

	property p_event_out;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		lanes.drop_event != LANE_CLEAR
			|=> o_drop_event == $past(lanes.drop_event);
	endproperty
	a_event_out: assert property (p_event_out)
		else $error("drop event not presented to status");

	property p_write;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		s_mask_write |=> power_good_irq_mask_group_three
			== $past(i_reg_wdata) ##1 o_mask == $past(i_reg_wdata, 2);
	endproperty
	a_write: assert property (p_write)
		else $error("mask write not stored in place");

	// ==========================================================
	// Readback, hold and reset-release checks
	sequence s_mask_read;
		i_reg_rd && hit;
	endsequence

	sequence s_released;
		$rose(rst_sync_b);
	endsequence

	// Readback returns the stored byte in bit order, one cycle later
	property p_read_back;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		s_mask_read |=> o_reg_rdata
			== $past(power_good_irq_mask_group_three);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("mask readback differs from stored value");

	// Reads away from the mask return zero
	property p_read_unmapped;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		i_reg_rd && !hit |=> o_reg_rdata == READ_UNMAPPED_VALUE;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped)
		else $error("unmapped read returned nonzero data");

	// Read data stands until the next read strobe
	property p_read_hold;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		!i_reg_rd |=> $stable(o_reg_rdata);
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("read data changed without a read");

	// Only a mask write may change the mask
	property p_mask_hold;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		!(i_reg_wr && hit)
			|=> $stable(power_good_irq_mask_group_three);
	endproperty
	a_mask_hold: assert property (p_mask_hold)
		else $error("mask changed without a write");

	// A lane low when reset lifts must not look like a drop
	property p_quiet_release;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		s_released |-> lanes.drop_event == LANE_CLEAR
			##1 lanes.drop_event == LANE_CLEAR;
	endproperty
	a_quiet_release: assert property (p_quiet_release)
		else $error("drop event raised by reset release");

	// A drop is one pulse; the lane must recover before the next
	property p_event_pulse;
		@(posedge i_sys_clk) disable iff (!rst_sync_b)
		lanes.drop_event != LANE_CLEAR |=> (lanes.drop_event
			& $past(lanes.drop_event)) == LANE_CLEAR;
	endproperty
	a_event_pulse: assert property (p_event_pulse)
		else $error("drop event held longer than one cycle");
endmodule // regulator_power_good_irq_mask
`default_nettype wire

// ### sim/tb_top.sv
/*
 * Self-checking bench for the power-good drop interrupt mask block.
 * Assumes the design package and a 100 MHz clock; inputs change on the
 * falling edge and results are compared two falling edges later.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import output_in_regulation_mask_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic       i_sys_clk   = 1'b0;
	logic       i_rst_b     = 1'b0;
	logic [7:0] i_reg_addr  = 8'h00;
	logic       i_reg_wr    = 1'b0;
	logic       i_reg_rd    = 1'b0;
	logic [7:0] i_reg_wdata = 8'h00;
	logic [7:0] pg          = 8'hff;
	logic [7:0] en          = 8'h00;
	logic [7:0] o_reg_rdata;
	logic [7:0] o_mask;
	logic [7:0] o_drop_event;
	logic       o_drop_irq;
	logic [8:0] q_exp[$];
	logic [8:0] exp_v;
	logic [1:0] kind        = 2'h0;
	logic [1:0] k1          = 2'h0;
	logic [1:0] k2          = 2'h0;
	logic [7:0] prev        = 8'hff;
	logic [7:0] mask        = MASK_GROUP_THREE_RESET;
	logic [7:0] seed        = 8'h23;
	int         n_mismatch  = 0;
	int         n_tests     = 0;

	regulator_power_good_irq_mask u_dut (
		.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
		.i_output_in_regulation(pg), .i_reg_enable(en),
		.o_reg_rdata(o_reg_rdata), .o_mask(o_mask),
		.o_drop_event(o_drop_event), .o_drop_irq(o_drop_irq));

	// Free-running clock
	always #5 i_sys_clk = ~i_sys_clk;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge i_sys_clk) begin
			kind = 2'h0;
			i_reg_wr = 1'b0;
			i_reg_rd = 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		{i_reg_wr, i_reg_addr, i_reg_wdata, kind} = {1'b1, a, d, 2'h0};
		if (a == MASK_GROUP_THREE_OFFSET) mask = d;
		idle(3);
	endtask

	// Read strobe; data is held until the next read, so space reads
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_sys_clk);
		{i_reg_rd, i_reg_addr, kind} = {1'b1, a, 2'h1};
		q_exp.push_back({1'b0, e});
		idle(3);
	endtask

	// One lane step; enable counts at the edge that sees the low level
	task automatic lane(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] ev;
		@(negedge i_sys_clk);
		{pg, en, kind} = {p, e, 2'h2};
		ev = prev & ~p & e;
		q_exp.push_back({|(ev & ~mask), ev});
		prev = p;
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========================================================
	// Result monitor: delays the step kind to match output latency
	always @(posedge i_sys_clk) begin
		k1 <= kind;
		k2 <= k1;
	end

	always @(negedge i_sys_clk) begin
		if (k2 != 2'h0 && q_exp.size() > 0) begin
			exp_v = q_exp.pop_front();
			if (k2 == 2'h1)
				check({1'b0, o_reg_rdata}, exp_v);
			else
				check({o_drop_irq, o_drop_event}, exp_v);
		end
	end

	// Watchdog sized well beyond the few hundred cycles used
	initial begin
		#200us;
		n_mismatch++;
		end_of_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge i_sys_clk);
		@(negedge i_sys_clk) i_rst_b = 1'b1;
		idle(4);
		check({1'b0, o_mask}, {1'b0, MASK_GROUP_THREE_RESET});
		rd(MASK_GROUP_THREE_OFFSET, MASK_GROUP_THREE_RESET);
		wr(8'h3f, 8'h00);
		rd(8'h3f, READ_UNMAPPED_VALUE);
		rd(MASK_GROUP_THREE_OFFSET, MASK_GROUP_THREE_RESET);
		// Each lane: unmasked drop, rise, drop while disabled
		for (int i = 0; i < LANE_COUNT; i++) begin
			wr(MASK_GROUP_THREE_OFFSET, ~(8'h01 << i));
			check({1'b0, o_mask}, {1'b0, mask});
			lane(8'hff, 8'hff);
			lane(~(8'h01 << i), 8'hff);
			lane(8'hff, 8'hff);
			lane(~(8'h01 << i), ~(8'h01 << i));
			idle(3);
		end
		// Random traffic with a fresh mask every eight steps
		for (int i = 0; i < 64; i++) begin
			if (i % 8 == 0) begin
				idle(3);
				seed = lfsr(seed);
				wr(MASK_GROUP_THREE_OFFSET, seed);
			end
			seed = lfsr(seed);
			lane(seed, lfsr(seed));
		end
		// All lanes low and enabled across the reset below
		lane(8'h00, 8'hff);
		idle(3);
		// Second reset in mid-run restores all masks
		@(negedge i_sys_clk) i_rst_b = 1'b0;
		prev = pg;
		mask = MASK_GROUP_THREE_RESET;
		@(negedge i_sys_clk) i_rst_b = 1'b1;
		idle(4);
		check({o_drop_irq, o_drop_event}, 9'h000);
		lane(8'hff, 8'hff);
		lane(8'h00, 8'hff);
		rd(MASK_GROUP_THREE_OFFSET, MASK_GROUP_THREE_RESET);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
